// *** rtl/srx_receiver.sv ***
// Purpose: Receive side of an asynchronous serial port with APB registers.
// Assumes: i_rt_tick pulses once per sample tick at 16 times the baud rate.
// Notes: Debug break protection and stop mode arrive as plain inputs.
`timescale 1ns/1ps
module srx_receiver #(
    parameter int P_ADDR_W = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [P_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_rt_tick,
    input wire logic i_serial_receive_pin,
    input wire logic i_stop_mode,
    input wire logic i_debug_break,
    input wire logic i_break_clear_enable_bit,
    output logic o_rx_irq,
    output logic o_err_irq,
    output logic o_wake_req
);
    import srx_pkg::*;

    if (P_ADDR_W < 5) begin : g_bad_addr
        $error("P_ADDR_W must be at least 5");
    end

    // ============================================================
    // Bus decode
    logic setup_ph, access_ph, wr_acc, rd_acc, mapped;
    logic [7:0] addr8;
    always_comb begin
        addr8 = 8'(i_paddr);
        setup_ph = i_psel && !i_penable;
        access_ph = i_psel && i_penable;
        wr_acc = access_ph && i_pwrite;
        rd_acc = access_ph && !i_pwrite;
        mapped = (addr8 == SRX_OFS_CTRL_ONE) || (addr8 == SRX_OFS_CTRL_TWO)
            || (addr8 == SRX_OFS_CTRL_THREE) || (addr8 == SRX_OFS_STATUS_ONE)
            || (addr8 == SRX_OFS_DATA_BUF);
    end
    assign o_pready = access_ph;
    assign o_pslverr = access_ph && !mapped;

    // ============================================================
    // Register state
    srx_ctrl_one_t c1_reg, c1_next;
    srx_ctrl_two_t c2_reg, c2_next;
    srx_ctrl_three_t c3_reg, c3_next;
    srx_status_t st_reg, st_next;
    logic [8:0] data_reg, data_next;
    logic armed_reg, armed_next, idle_arm_reg, idle_arm_next;
    logic [31:0] prdata_reg, prdata_next;

    // Receiver events into the register group.
    logic ev_char, ev_idle, ev_nf, ev_fe, ev_pe, ev_msb;
    logic [8:0] ev_data;

    logic rx_active, protect;
    assign rx_active = c1_reg.enable && c2_reg.rx_en;
    assign protect = i_debug_break && !i_break_clear_enable_bit;

    // ============================================================
    // Receiver sampling
    srx_state_t state_reg, state_next;
    logic [4:0] rt_reg, rt_next;
    logic [3:0] bit_reg, bit_next;
    logic [2:0] samp_reg, samp_next, hist_reg, hist_next;
    logic [8:0] shift_reg, shift_next;
    logic [3:0] icnt_reg, icnt_next;
    logic noise_reg, noise_next, prev_reg, prev_next, last_reg, last_next;
    logic [3:0] stop_idx, idle_goal;
    logic rxd, maj, split;
    logic [2:0] vote;

    always_comb begin
        rxd = i_serial_receive_pin;
        stop_idx = SRX_STOP_IDX_8 + {3'h0, c1_reg.nine_bit};
        idle_goal = SRX_IDLE_BITS_8 + {3'h0, c1_reg.nine_bit};
        // The tick-10 sample is still on the pin, not yet in samp_reg.
        vote = {samp_reg[1:0], rxd};
        maj = (vote[2] & vote[1]) | (vote[2] & vote[0])
            | (vote[1] & vote[0]);
        split = (vote != 3'h0) && (vote != 3'h7);
        state_next = state_reg;
        rt_next = rt_reg;
        bit_next = bit_reg;
        samp_next = samp_reg;
        hist_next = hist_reg;
        shift_next = shift_reg;
        icnt_next = icnt_reg;
        noise_next = noise_reg;
        prev_next = prev_reg;
        last_next = last_reg;
        ev_char = 1'b0;
        ev_idle = 1'b0;
        ev_fe = 1'b0;
        ev_nf = 1'b0;
        ev_pe = 1'b0;
        ev_msb = shift_reg[8];
        ev_data = c1_reg.nine_bit ? shift_reg : {shift_reg[8], shift_reg[8:1]};
        if (i_stop_mode) begin
            // Hold everything; a character in flight is simply resumed late.
            state_next = state_reg;
        end else if (!rx_active) begin
            state_next = SRX_HUNT;
            rt_next = 5'h01;
            hist_next = 3'h0;
            icnt_next = 4'h0;
        end else if (i_rt_tick) begin
            last_next = rxd;
            rt_next = (rt_reg == SRX_RT_PER_BIT) ? 5'h01 : rt_reg + 5'h01;
            if ((rt_reg >= SRX_RT_VOTE_A) && (rt_reg <= SRX_RT_VOTE_C)) begin
                samp_next = {samp_reg[1:0], rxd};
            end
            case (state_reg)
                SRX_HUNT: begin
                    hist_next = {hist_reg[1:0], rxd};
                    if (!rxd && (hist_reg == 3'h7)) begin
                        state_next = SRX_CHAR;
                        rt_next = 5'h02;
                        bit_next = 4'h0;
                        noise_next = 1'b0;
                        samp_next = 3'h0;
                        // The start bit is a zero, so any run of ones ends.
                        icnt_next = 4'h0;
                    end else if (!rxd) begin
                        icnt_next = 4'h0;
                    end else if ((rt_reg == SRX_RT_VOTE_C)
                                 && (icnt_reg != idle_goal)) begin
                        icnt_next = icnt_reg + 4'h1;
                        ev_idle = (icnt_reg + 4'h1) == idle_goal;
                    end
                end
                SRX_CHAR: begin
                    if (bit_reg == 4'h0) begin
                        if ((rt_reg == SRX_RT_START_A)
                            || (rt_reg == SRX_RT_START_B)
                            || (rt_reg == SRX_RT_START_C)) begin
                            samp_next = {samp_reg[1:0], rxd};
                        end
                        if (rt_reg == SRX_RT_START_C) begin
                            if ((samp_reg[1] & samp_reg[0])
                                | (samp_reg[1] & rxd)
                                | (samp_reg[0] & rxd)) begin
                                state_next = SRX_HUNT;
                                hist_next = 3'h0;
                            end else if ({samp_reg[1:0], rxd} != 3'h0) begin
                                noise_next = 1'b1;
                            end
                            samp_next = 3'h0;
                        end
                    end
                    if (rt_reg == SRX_RT_PER_BIT) begin
                        bit_next = bit_reg + 4'h1;
                    end
                    if (rt_reg == SRX_RT_VOTE_C) begin
                        if (split) begin
                            noise_next = 1'b1;
                        end
                        if (bit_reg == 4'h0) begin
                            noise_next = noise_reg || (vote != 3'h0);
                        end else if (bit_reg == stop_idx) begin
                            ev_char = 1'b1;
                            ev_fe = !maj;
                            ev_nf = noise_reg || split;
                            ev_pe = c1_reg.par_en
                                && ((c1_reg.nine_bit ? ^shift_reg
                                     : ^shift_reg[8:1]) != c1_reg.par_odd);
                            state_next = SRX_HUNT;
                            hist_next = {3{maj}};
                            icnt_next = (c1_reg.idle_start || !maj) ? 4'h0
                                : icnt_reg + 4'h1;
                        end else begin
                            shift_next = {maj, shift_reg[8:1]};
                            prev_next = maj;
                            icnt_next = (maj && !c1_reg.idle_start)
                                ? icnt_reg + 4'h1 : 4'h0;
                        end
                    end
                    // A falling edge after a one realigns the bit clock.
                    if ((bit_reg != 4'h0) && (bit_reg != stop_idx) && last_reg
                        && !rxd && prev_reg
                        && ((rt_reg < SRX_RT_VOTE_A)
                            || (rt_reg > SRX_RT_VOTE_C))) begin
                        rt_next = 5'h02;
                        if (rt_reg > SRX_RT_VOTE_C) begin
                            bit_next = bit_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    state_next = SRX_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= SRX_HUNT;
            rt_reg <= 5'h01;
            bit_reg <= 4'h0;
            samp_reg <= 3'h0;
            hist_reg <= 3'h0;
            shift_reg <= SRX_DATA_RST;
            icnt_reg <= 4'h0;
            noise_reg <= 1'b0;
            prev_reg <= 1'b0;
            last_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            rt_reg <= rt_next;
            bit_reg <= bit_next;
            samp_reg <= samp_next;
            hist_reg <= hist_next;
            shift_reg <= shift_next;
            icnt_reg <= icnt_next;
            noise_reg <= noise_next;
            prev_reg <= prev_next;
            last_reg <= last_next;
        end
    end

    // ============================================================
    // Registers, flags and clearing
    logic accept, wr_c2, rd_st, rd_dat;
    always_comb begin
        c1_next = c1_reg;
        c2_next = c2_reg;
        c3_next = c3_reg;
        st_next = st_reg;
        data_next = data_reg;
        armed_next = armed_reg;
        idle_arm_next = idle_arm_reg;
        wr_c2 = wr_acc && (addr8 == SRX_OFS_CTRL_TWO);
        rd_st = rd_acc && (addr8 == SRX_OFS_STATUS_ONE);
        rd_dat = rd_acc && (addr8 == SRX_OFS_DATA_BUF);
        accept = ev_char
            && (!c2_reg.standby || (c1_reg.wake_addr && ev_msb));
        if (wr_acc && (addr8 == SRX_OFS_CTRL_ONE)) begin
            c1_next = i_pwdata[5:0];
        end
        if (wr_c2) begin
            c2_next = i_pwdata[3:0];
        end
        if (wr_acc && (addr8 == SRX_OFS_CTRL_THREE)) begin
            c3_next = i_pwdata[3:0];
        end
        // Clearing is a status read followed by a data read.
        if (rd_st && !protect) begin
            armed_next = 1'b1;
        end
        if (rd_dat && armed_reg && !protect) begin
            st_next = '0;
            armed_next = 1'b0;
        end
        // Hardware sets are applied last so they win over a clear.
        if (ev_char) begin
            idle_arm_next = 1'b1;
        end
        if (accept) begin
            if (c2_reg.standby) begin
                c2_next.standby = 1'b0;
            end
            if (st_reg.full) begin
                st_next.ovr = 1'b1;
            end else begin
                data_next = ev_data;
                st_next.full = 1'b1;
                st_next.frame = st_next.frame | ev_fe;
                st_next.noise = st_next.noise | ev_nf;
                st_next.par = st_next.par | ev_pe;
            end
        end
        if (ev_idle) begin
            if (c2_reg.standby && !c1_reg.wake_addr) begin
                c2_next.standby = 1'b0;
            end else if (!c2_reg.standby && idle_arm_reg) begin
                st_next.idle = 1'b1;
                idle_arm_next = 1'b0;
            end
        end
        prdata_next = prdata_reg;
        if (setup_ph) begin
            case (addr8)
                SRX_OFS_CTRL_ONE: prdata_next = {26'h0, c1_reg};
                SRX_OFS_CTRL_TWO: prdata_next = {28'h0, c2_reg};
                SRX_OFS_CTRL_THREE: prdata_next = {28'h0, c3_reg};
                SRX_OFS_STATUS_ONE: prdata_next = {26'h0, st_reg};
                SRX_OFS_DATA_BUF: prdata_next = {23'h0, data_reg};
                default: prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            c1_reg <= SRX_CTRL_RST;
            c2_reg <= SRX_CTRL_RST[3:0];
            c3_reg <= SRX_CTRL_RST[3:0];
            st_reg <= SRX_CTRL_RST;
            data_reg <= SRX_DATA_RST;
            armed_reg <= 1'b0;
            idle_arm_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            c1_reg <= c1_next;
            c2_reg <= c2_next;
            c3_reg <= c3_next;
            st_reg <= st_next;
            data_reg <= data_next;
            armed_reg <= armed_next;
            idle_arm_reg <= idle_arm_next;
            prdata_reg <= prdata_next;
        end
    end
    assign o_prdata = prdata_reg;

    // ============================================================
    // Interrupt requests; they stay live in wait mode to wake the core.
    logic rx_req, err_req;
    assign rx_req = (c2_reg.rx_ie && st_reg.full)
        || (c2_reg.idle_ie && st_reg.idle);
    assign err_req = (c3_reg.ovr_ie && st_reg.ovr)
        || (c3_reg.noise_ie && st_reg.noise)
        || (c3_reg.frame_ie && st_reg.frame)
        || (c3_reg.par_ie && st_reg.par);
    assign o_rx_irq = rx_req && !c2_reg.standby;
    assign o_err_irq = err_req && !c2_reg.standby;
    assign o_wake_req = o_rx_irq || o_err_irq;

    // ============================================================
    // Checks
    chk_frame_with_full: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) $rose(st_reg.frame) |-> $rose(st_reg.full))
        else $error("framing error rose without receive full");
    chk_stop_position: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) ev_char |-> (rt_reg == SRX_RT_VOTE_C)
            && (bit_reg == (c1_reg.nine_bit ? 4'ha : 4'h9)))
        else $error("stop bit voted at wrong position");
    chk_standby_quiet: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) c2_reg.standby |-> !o_rx_irq && !o_err_irq)
        else $error("interrupt request while in standby");
    chk_overrun_keeps: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) $rose(st_reg.ovr) |-> $stable(data_reg))
        else $error("overrun replaced buffered data");
    chk_addr_wake_full: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) $fell(c2_reg.standby) && c1_reg.wake_addr
            && !$past(wr_c2) |-> $rose(st_reg.full) || st_reg.ovr)
        else $error("address wake without receive full");
    chk_idle_wake_quiet: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) $fell(c2_reg.standby) && !c1_reg.wake_addr
            && !$past(wr_c2) |-> !$rose(st_reg.idle) && !$rose(st_reg.full))
        else $error("idle wake set a flag");
    chk_break_guard: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) $past(protect) |-> !$fell(st_reg.full)
            && !$fell(st_reg.frame) && !$fell(st_reg.idle))
        else $error("flag cleared during protected break");
    chk_stop_freeze: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) $past(i_stop_mode) |-> $stable(rt_reg)
            && $stable(bit_reg) && $stable(shift_reg))
        else $error("receiver moved in stop mode");
    chk_err_gated: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) st_reg.frame && !c3_reg.frame_ie
            && !st_reg.ovr && !st_reg.noise && !st_reg.par |-> !o_err_irq)
        else $error("ungated framing error request");
    cov_frame: cover property (@(posedge i_sys_clk) $rose(st_reg.frame));
    cov_overrun: cover property (@(posedge i_sys_clk) $rose(st_reg.ovr));
    cov_idle: cover property (@(posedge i_sys_clk) $rose(st_reg.idle));
    cov_wake: cover property (@(posedge i_sys_clk) $fell(c2_reg.standby));

endmodule : srx_receiver

// *** rtl/srx_pkg.sv ***
// Purpose: Shared constants and types for the serial receiver block.
// Assumes: APB register access with 32-bit data, one word per register.
// Notes: Bit positions refer to the low bits of each register word.
package srx_pkg;

    // ============================================================
    // Register byte offsets
    localparam logic [7:0] SRX_OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] SRX_OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] SRX_OFS_CTRL_THREE = 8'h08;
    localparam logic [7:0] SRX_OFS_STATUS_ONE = 8'h0c;
    localparam logic [7:0] SRX_OFS_DATA_BUF = 8'h10;

    // ============================================================
    // Field positions
    // The packed structs below put their first field in the highest bit.
    localparam int SRX_C1_ENABLE = 5;
    localparam int SRX_C1_NINE_BIT = 4;
    localparam int SRX_C1_WAKE_ADDR = 3;
    localparam int SRX_C1_IDLE_START = 2;
    localparam int SRX_C1_PAR_EN = 1;
    localparam int SRX_C1_PAR_ODD = 0;
    localparam int SRX_C2_RX_IE = 3;
    localparam int SRX_C2_IDLE_IE = 2;
    localparam int SRX_C2_RX_EN = 1;
    localparam int SRX_C2_STANDBY = 0;
    localparam int SRX_C3_OVR_IE = 3;
    localparam int SRX_C3_NOISE_IE = 2;
    localparam int SRX_C3_FRAME_IE = 1;
    localparam int SRX_C3_PAR_IE = 0;
    localparam int SRX_S1_FULL = 5;
    localparam int SRX_S1_IDLE = 4;
    localparam int SRX_S1_OVR = 3;
    localparam int SRX_S1_NOISE = 2;
    localparam int SRX_S1_FRAME = 1;
    localparam int SRX_S1_PAR = 0;

    // ============================================================
    // Reset values and timing
    localparam logic [5:0] SRX_CTRL_RST = 6'h00;
    localparam logic [8:0] SRX_DATA_RST = 9'h000;
    localparam logic [4:0] SRX_RT_PER_BIT = 5'h10;
    localparam logic [4:0] SRX_RT_START_A = 5'h03;
    localparam logic [4:0] SRX_RT_START_B = 5'h05;
    localparam logic [4:0] SRX_RT_START_C = 5'h07;
    localparam logic [4:0] SRX_RT_VOTE_A = 5'h08;
    localparam logic [4:0] SRX_RT_VOTE_C = 5'h0a;
    localparam logic [3:0] SRX_STOP_IDX_8 = 4'h9;
    localparam logic [3:0] SRX_IDLE_BITS_8 = 4'ha;

    // ============================================================
    // Types
    typedef struct packed {
        logic enable;
        logic nine_bit;
        logic wake_addr;
        logic idle_start;
        logic par_en;
        logic par_odd;
    } srx_ctrl_one_t;

    typedef struct packed {
        logic rx_ie;
        logic idle_ie;
        logic rx_en;
        logic standby;
    } srx_ctrl_two_t;

    typedef struct packed {
        logic ovr_ie;
        logic noise_ie;
        logic frame_ie;
        logic par_ie;
    } srx_ctrl_three_t;

    typedef struct packed {
        logic full;
        logic idle;
        logic ovr;
        logic noise;
        logic frame;
        logic par;
    } srx_status_t;

    typedef enum logic [0:0] {
        SRX_HUNT,
        SRX_CHAR
    } srx_state_t;

endpackage : srx_pkg

// *** tb/srx_line_model.sv ***
// Purpose: Remote transmitter model that drives the receive line.
// Assumes: One bit lasts sixteen sample ticks; the line idles high.
// Notes: The stop value is an argument so breaks can be sent on demand.
`timescale 1ns/1ps
module srx_line_model (
    input wire logic i_sys_clk,
    input wire logic i_rt_tick,
    output logic o_line
);
    initial o_line = 1'b1;

    // ==============================================================
    // Frame sender
    // Bits change just after a tick edge, start bit first, LSB next.
    task automatic send(input logic [8:0] d, input int n,
                        input logic stop_v);
        for (int i = 0; i <= n + 1; i++) begin
            o_line <= (i == 0) ? 1'b0 : ((i > n) ? stop_v : d[i-1]);
            repeat (16) @(posedge i_sys_clk iff i_rt_tick);
        end
        o_line <= 1'b1;
    endtask : send

    // A one-tick dip at the middle stop sample gives a split vote.
    task automatic send_dip(input logic [8:0] d, input int n);
        for (int i = 0; i <= n; i++) begin
            o_line <= (i == 0) ? 1'b0 : d[i-1];
            repeat (16) @(posedge i_sys_clk iff i_rt_tick);
        end
        o_line <= 1'b1;
        repeat (8) @(posedge i_sys_clk iff i_rt_tick);
        o_line <= 1'b0;
        @(posedge i_sys_clk iff i_rt_tick);
        o_line <= 1'b1;
        repeat (7) @(posedge i_sys_clk iff i_rt_tick);
    endtask : send_dip
endmodule : srx_line_model

// *** tb/srx_receiver_bench.sv ***
// Purpose: Self-checking bench for the serial receiver block.
// Assumes: Zero-wait APB slave; sample tick every second clock.
// Notes: Stop mode is raised once, across one whole character.
`timescale 1ns/1ps
module srx_receiver_bench;
    import srx_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, ser, tick = 1'b0, line, dbg = 1'b0;
    logic rx_irq, err_irq, stp = 1'b0;
    int err_total = 0;
    int n_checks = 0;

    always #5 clk = ~clk;
    always @(posedge clk) tick <= ~tick;

    srx_line_model i_model (.i_sys_clk(clk), .i_rt_tick(tick),
        .o_line(line));
    srx_receiver i_dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_rt_tick(tick),
        .i_serial_receive_pin(line), .i_stop_mode(stp),
        .i_debug_break(dbg), .i_break_clear_enable_bit(1'b0),
        .o_rx_irq(rx_irq), .o_err_irq(err_irq), .o_wake_req());

    // ==============================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        ser = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rdv, e);
    endtask : rchk
    task automatic bits(input int n);
        repeat (n * 16) @(posedge clk iff tick);
    endtask : bits
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // ==============================================================
    // Scenarios
    task automatic t_reset;
        rchk(SRX_OFS_STATUS_ONE, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, ser}, 32'h1);
        apb(1'b1, SRX_OFS_CTRL_ONE, 32'h20);
        apb(1'b1, SRX_OFS_CTRL_TWO, 32'h0e);
        apb(1'b1, SRX_OFS_CTRL_THREE, 32'h0f);
    endtask : t_reset
    task automatic t_break;
        // The receiver needs three ones on the line before a start edge.
        bits(1);
        i_model.send(9'h000, 8, 1'b0);
        check({31'h0, err_irq}, 32'h1);
        apb(1'b1, SRX_OFS_CTRL_THREE, 32'h0d);
        @(posedge clk);
        check({31'h0, err_irq}, 32'h0);
        apb(1'b1, SRX_OFS_CTRL_THREE, 32'h0f);
        rchk(SRX_OFS_STATUS_ONE, 32'h22);
        dbg <= 1'b1;
        rchk(SRX_OFS_DATA_BUF, 32'h0);
        rchk(SRX_OFS_STATUS_ONE, 32'h22);
        dbg <= 1'b0;
        rchk(SRX_OFS_DATA_BUF, 32'h0);
        rchk(SRX_OFS_STATUS_ONE, 32'h0);
    endtask : t_break
    task automatic t_idle;
        bits(12);
        check({31'h0, rx_irq}, 32'h1);
        rchk(SRX_OFS_STATUS_ONE, 32'h10);
        apb(1'b0, SRX_OFS_DATA_BUF, 32'h0);
    endtask : t_idle
    task automatic t_char;
        i_model.send(9'h0a5, 8, 1'b1);
        check({31'h0, rx_irq}, 32'h1);
        i_model.send(9'h03c, 8, 1'b1);
        check({31'h0, err_irq}, 32'h1);
        rchk(SRX_OFS_STATUS_ONE, 32'h28);
        rchk(SRX_OFS_DATA_BUF, 32'h1a5);
        apb(1'b1, SRX_OFS_CTRL_ONE, 32'h22);
        i_model.send(9'h001, 8, 1'b1);
        rchk(SRX_OFS_STATUS_ONE, 32'h21);
        apb(1'b0, SRX_OFS_DATA_BUF, 32'h0);
        apb(1'b1, SRX_OFS_CTRL_ONE, 32'h30);
        i_model.send(9'h15a, 9, 1'b1);
        rchk(SRX_OFS_STATUS_ONE, 32'h20);
        rchk(SRX_OFS_DATA_BUF, 32'h15a);
        i_model.send_dip(9'h0f0, 9);
        check({31'h0, err_irq}, 32'h1);
        rchk(SRX_OFS_STATUS_ONE, 32'h24);
        rchk(SRX_OFS_DATA_BUF, 32'h0f0);
    endtask : t_char
    task automatic t_standby;
        apb(1'b1, SRX_OFS_CTRL_ONE, 32'h28);
        apb(1'b1, SRX_OFS_CTRL_TWO, 32'h0f);
        i_model.send(9'h005, 8, 1'b1);
        rchk(SRX_OFS_CTRL_TWO, 32'h0f);
        rchk(SRX_OFS_STATUS_ONE, 32'h0);
        i_model.send(9'h085, 8, 1'b1);
        check({31'h0, rx_irq}, 32'h1);
        rchk(SRX_OFS_CTRL_TWO, 32'h0e);
        rchk(SRX_OFS_STATUS_ONE, 32'h20);
        apb(1'b1, SRX_OFS_CTRL_ONE, 32'h24);
        apb(1'b1, SRX_OFS_CTRL_TWO, 32'h0b);
        bits(12);
        rchk(SRX_OFS_CTRL_TWO, 32'h0a);
        rchk(SRX_OFS_STATUS_ONE, 32'h20);
    endtask : t_standby
    task automatic t_stop;
        rchk(SRX_OFS_STATUS_ONE, 32'h20);
        apb(1'b0, SRX_OFS_DATA_BUF, 32'h0);
        stp <= 1'b1;
        i_model.send(9'h055, 8, 1'b1);
        check({31'h0, rx_irq}, 32'h0);
        rchk(SRX_OFS_CTRL_ONE, 32'h24);
        stp <= 1'b0;
        i_model.send(9'h055, 8, 1'b1);
        check({31'h0, rx_irq}, 32'h1);
        rchk(SRX_OFS_DATA_BUF, 32'h055);
    endtask : t_stop

    // ==============================================================
    // Main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_break();
        t_idle();
        t_char();
        t_idle();
        t_standby();
        t_stop();
        wrap_up();
    end
    // The run needs about 4600 cycles; the limit leaves ample margin.
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule : srx_receiver_bench
